/* rtl/serial_pkg.sv */
// How it works
// - Bit rate is source over sixteen times divisor.
// - Divisor one is smallest, fastest legal value.
// - Source is base times multiplier times prescaler, capped at 192000 kHz.
// - Receiver tolerates -3.0/+2.5 percent rate error.
// - Port A: two lines, 4 Mbit/s, 256-byte FIFO.
// - Port B: two lines, 1 Mbit/s, 64-byte FIFO.
// - Port B lines switchable to CAN, serial default.
// - Registers behave like a 16550-class controller.
// - Divisor register sets and changes bit timing.
package serial_pkg;
   localparam logic [18:0] CLK_KHZ = 19'h30D40;
   localparam logic [31:0] BASE_A_KHZ = 32'h00003000;
   localparam logic [31:0] BASE_B_KHZ = 32'h000061A8;
   localparam logic [31:0] BASE_C_KHZ = 32'h0000BB80;
   localparam logic [31:0] SRC_MAX_KHZ = 32'h0002EE00;
   localparam logic [2:0] PLL_MAX = 3'h6;
   localparam logic [4:0] PRESCALE_MAX = 5'h10;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] SAMPLE_LAST = 4'hF;
   localparam int DEPTH_A = 256;
   localparam int DEPTH_B = 64;
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_IER = 3'h1;
   localparam logic [2:0] REG_FCR = 3'h2;
   localparam logic [2:0] REG_LCR = 3'h3;
   localparam logic [2:0] REG_MCR = 3'h4;
   localparam logic [2:0] REG_LSR = 3'h5;
   localparam logic [2:0] REG_MSR = 3'h6;
   localparam logic [2:0] REG_SCR = 3'h7;
   localparam logic [7:0] CFG_ADDR = 8'h40;
   localparam logic [7:0] SRC_ADDR = 8'h44;
   localparam logic [31:0] CFG_MASK = 32'h00011F1F;
   localparam logic [31:0] CFG_RESET = 32'h00000105;
   localparam int CFG_CAN_BIT = 16;
   localparam logic [15:0] DIV_RESET = 16'h000C;
   localparam logic [7:0] LCR_RESET = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_START = 3'b001,
      S_DATA = 3'b010,
      S_PARITY = 3'b011,
      S_STOP = 3'b100
   } line_state_t;

   function automatic logic [31:0] source_khz(input logic [1:0] base_sel, input logic [2:0] pll,
                                              input logic [4:0] pre);
      logic [31:0] base;
      logic [31:0] prod;
      logic [2:0] m;
      logic [4:0] d;
      base = (base_sel == 2'h0) ? BASE_A_KHZ : ((base_sel == 2'h1) ? BASE_B_KHZ : BASE_C_KHZ);
      m = (pll == 3'h0) ? 3'h1 : ((pll > PLL_MAX) ? PLL_MAX : pll);
      d = (pre == 5'h00) ? 5'h01 : ((pre > PRESCALE_MAX) ? PRESCALE_MAX : pre);
      prod = base * {29'h0, m} * {27'h0, d};
      source_khz = (prod > SRC_MAX_KHZ) ? SRC_MAX_KHZ : prod;
   endfunction : source_khz

   function automatic logic [7:0] word_mask(input logic [1:0] len);
      word_mask = 8'hFF >> (2'h3 - len);
   endfunction : word_mask

   function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] len, input logic even);
      parity_bit = (^(data & word_mask(len))) ^ ~even;
   endfunction : parity_bit
endpackage : serial_pkg

/* rtl/stream_if.sv */
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if

/* rtl/fifo_buf.sv */
`timescale 1ns/100ps
module fifo_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic flush_in,
   stream_if.snk wr_s,
   stream_if.src rd_s,
   output logic empty_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic rv_q;
   logic [WIDTH-1:0] rd_q;
   wire push = wr_s.valid & wr_s.ready;
   wire load = ce_in & ~flush_in & (cnt_q != '0) & (~rv_q | rd_s.ready);
   wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

   // Ready ignores flush, so no loop runs back through the writer's stall logic.
   assign wr_s.ready = ce_in & (cnt_q != (AW+1)'(DEPTH));
   assign rd_s.valid = rv_q;
   assign rd_s.data = rd_q;
   assign empty_out = ~rv_q & (cnt_q == '0);

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_s.data;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rv_q <= 1'b0;
         rd_q <= '0;
      end else if (ce_in && flush_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rv_q <= 1'b0;
      end else if (ce_in) begin
         wp_q <= push ? wp_q + AW'(1) : wp_q;
         rp_q <= load ? rp_q + AW'(1) : rp_q;
         rd_q <= load ? mem_q[rp_q] : rd_q;
         cnt_q <= cnt_d;
         rv_q <= load | (rv_q & ~rd_s.ready);
      end
   end
endmodule : fifo_buf

/* rtl/serial_port_baud_generator.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module serial_port_baud_generator (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [7:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   input wire logic rxd_a_in,
   output logic txd_a_out,
   input wire logic rxd_b_in,
   output logic txd_b_out,
   input wire logic can_tx_in,
   output logic can_rx_out
);
   logic aw_held_q;
   logic w_held_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [31:0] cfg_q;
   logic [18:0] acc_q;
   logic src_tick_q;
   logic can_rx_q;
   wire [1:0] thr_blocked;
   wire [1:0] txd_w;
   wire [1:0] rx_sync_w;
   wire [1:0] rxd_w = {rxd_b_in, rxd_a_in};
   wire [7:0] port_rdata [2];

   wire can_sel = cfg_q[serial_pkg::CFG_CAN_BIT];
   wire wr_port_win = (aw_addr_q[7:6] == 2'h0);
   wire wr_port = aw_addr_q[5];
   wire [2:0] wr_idx = aw_addr_q[4:2];
   wire wr_cfg = (aw_addr_q == serial_pkg::CFG_ADDR);
   wire wr_known = wr_port_win | wr_cfg | (aw_addr_q == serial_pkg::SRC_ADDR);
   // A data write to a full transmit FIFO waits rather than losing the byte.
   wire wr_stall = wr_port_win & thr_blocked[wr_port];
   wire wr_go = ce_in & aw_held_q & w_held_q & ~bvalid_q & ~wr_stall;
   wire rd_go = ce_in & arvalid_in & ~rvalid_q;
   wire rd_port_win = (araddr_in[7:6] == 2'h0);
   wire rd_cfg = (araddr_in == serial_pkg::CFG_ADDR);
   wire rd_src = (araddr_in == serial_pkg::SRC_ADDR);
   wire [31:0] src_khz = serial_pkg::source_khz(cfg_q[1:0], cfg_q[4:2], cfg_q[12:8]);
   wire [31:0] rd_word = rd_port_win ? {24'h000000, port_rdata[araddr_in[5]]} :
                         (rd_cfg ? cfg_q : (rd_src ? src_khz : 32'h00000000));
   wire [31:0] cfg_wr = {w_strb_q[3] ? w_data_q[31:24] : cfg_q[31:24],
                         w_strb_q[2] ? w_data_q[23:16] : cfg_q[23:16],
                         w_strb_q[1] ? w_data_q[15:8] : cfg_q[15:8],
                         w_strb_q[0] ? w_data_q[7:0] : cfg_q[7:0]};
   wire [19:0] acc_sum = {1'b0, acc_q} + {1'b0, src_khz[18:0]};
   wire src_tick = (acc_sum >= {1'b0, serial_pkg::CLK_KHZ});
   wire [19:0] acc_next = src_tick ? acc_sum - {1'b0, serial_pkg::CLK_KHZ} : acc_sum;

   assign awready_out = ce_in & ~aw_held_q & ~bvalid_q;
   assign wready_out = ce_in & ~w_held_q & ~bvalid_q;
   assign arready_out = ce_in & ~rvalid_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign rvalid_out = rvalid_q;
   assign rresp_out = rresp_q;
   assign rdata_out = rdata_q;
   assign txd_a_out = txd_w[0];
   assign txd_b_out = txd_w[1];
   assign can_rx_out = can_rx_q;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= serial_pkg::RESP_OKAY;
      end else if (ce_in) begin
         if (awvalid_in && awready_out) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr_in;
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (wvalid_in && wready_out) begin
            w_held_q <= 1'b1;
            w_data_q <= wdata_in;
            w_strb_q <= wstrb_in;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
         end else if (bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= serial_pkg::RESP_OKAY;
      end else if (ce_in) begin
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_port_win | rd_cfg | rd_src) ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
         end else if (rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // The source tick is a fractional division of the fixed clock, so its mean rate is exact.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_q <= serial_pkg::CFG_RESET;
         acc_q <= 19'h00000;
         src_tick_q <= 1'b0;
         can_rx_q <= 1'b1;
      end else if (ce_in) begin
         if (wr_go && wr_cfg) begin
            cfg_q <= cfg_wr & serial_pkg::CFG_MASK;
         end
         acc_q <= acc_next[18:0];
         src_tick_q <= src_tick;
         can_rx_q <= can_sel ? rx_sync_w[1] : 1'b1;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_port
      localparam int DEPTH = (p == 0) ? serial_pkg::DEPTH_A : serial_pkg::DEPTH_B;
      stream_if #(.W(8)) txi ();
      stream_if #(.W(8)) txo ();
      stream_if #(.W(8)) rxi ();
      stream_if #(.W(8)) rxo ();
      logic [7:0] dll_q;
      logic [7:0] dlm_q;
      logic [7:0] ier_q;
      logic [7:0] lcr_q;
      logic [7:0] mcr_q;
      logic [7:0] scr_q;
      logic fifo_en_q;
      logic oe_q;
      logic pe_q;
      logic fe_q;
      logic [15:0] div_cnt_q;
      serial_pkg::line_state_t tx_st_q;
      serial_pkg::line_state_t rx_st_q;
      logic [3:0] tx_sub_q;
      logic [3:0] rx_sub_q;
      logic [2:0] tx_bit_q;
      logic [2:0] rx_bit_q;
      logic [7:0] tx_sh_q;
      logic [7:0] rx_sh_q;
      logic tx_par_q;
      logic tx_line_q;
      logic rx_perr_q;
      logic rx_s1_q;
      logic rx_s2_q;
      logic pin_q;
      logic tx_empty;

      wire dlab = lcr_q[7];
      wire [2:0] last_bit = 3'h4 + {1'b0, lcr_q[1:0]};
      wire we = wr_go & wr_port_win & (wr_port == 1'(p)) & w_strb_q[0];
      wire [7:0] wbyte = w_data_q[7:0];
      wire rd_hit = rd_go & rd_port_win & (araddr_in[5] == 1'(p));
      wire [2:0] ridx = araddr_in[4:2];
      wire lsr_rd = rd_hit & (ridx == serial_pkg::REG_LSR);
      wire flush_tx = we & (wr_idx == serial_pkg::REG_FCR) & wbyte[2];
      wire flush_rx = we & (wr_idx == serial_pkg::REG_FCR) & wbyte[1];
      wire [15:0] div_val = {dlm_q, dll_q};
      wire [15:0] eff_div = (div_val == 16'h0000) ? 16'h0001 : div_val;
      wire smp_tick = src_tick_q & (div_cnt_q <= 16'h0001);
      wire port_can = (p == 1) & can_sel;
      wire rx_line = mcr_q[4] ? tx_line_q : (port_can ? 1'b1 : rx_s2_q);
      wire rx_push = ce_in & smp_tick & (rx_st_q == serial_pkg::S_STOP) & (rx_sub_q == serial_pkg::SAMPLE_LAST);
      wire thre = tx_empty;
      wire temt = tx_empty & (tx_st_q == serial_pkg::S_IDLE);
      wire [7:0] lsr = {1'b0, temt, thre, 1'b0, fe_q, pe_q, oe_q, rxo.valid};
      wire [7:0] iir = {fifo_en_q, fifo_en_q, 5'h00, 1'b1};

      assign txi.valid = we & (wr_idx == serial_pkg::REG_DATA) & ~dlab;
      assign txi.data = wbyte;
      assign thr_blocked[p] = (wr_idx == serial_pkg::REG_DATA) & ~dlab & w_strb_q[0] & ~txi.ready;
      assign txo.ready = ce_in & smp_tick & (tx_st_q == serial_pkg::S_IDLE);
      assign rxi.valid = rx_push;
      assign rxi.data = rx_sh_q & serial_pkg::word_mask(lcr_q[1:0]);
      assign rxo.ready = rd_hit & (ridx == serial_pkg::REG_DATA) & ~dlab;
      assign txd_w[p] = pin_q;
      assign rx_sync_w[p] = rx_s2_q;
      assign port_rdata[p] = (ridx == serial_pkg::REG_DATA) ? (dlab ? dll_q : rxo.data) :
                             (ridx == serial_pkg::REG_IER) ? (dlab ? dlm_q : ier_q) :
                             (ridx == serial_pkg::REG_FCR) ? iir :
                             (ridx == serial_pkg::REG_LCR) ? lcr_q :
                             (ridx == serial_pkg::REG_MCR) ? mcr_q :
                             (ridx == serial_pkg::REG_LSR) ? lsr :
                             (ridx == serial_pkg::REG_MSR) ? 8'h00 : scr_q;

      fifo_buf #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
         .clk_in(clk_in),
         .rst_b_in(rst_b_in),
         .ce_in(ce_in),
         .flush_in(flush_tx),
         .wr_s(txi),
         .rd_s(txo),
         .empty_out(tx_empty)
      );

      fifo_buf #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
         .clk_in(clk_in),
         .rst_b_in(rst_b_in),
         .ce_in(ce_in),
         .flush_in(flush_rx),
         .wr_s(rxi),
         .rd_s(rxo),
         .empty_out()
      );

      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            dll_q <= serial_pkg::DIV_RESET[7:0];
            dlm_q <= serial_pkg::DIV_RESET[15:8];
            ier_q <= 8'h00;
            lcr_q <= serial_pkg::LCR_RESET;
            mcr_q <= 8'h00;
            scr_q <= 8'h00;
            fifo_en_q <= 1'b0;
         end else if (ce_in && we) begin
            case (wr_idx)
               serial_pkg::REG_DATA: dll_q <= dlab ? wbyte : dll_q;
               serial_pkg::REG_IER: begin
                  dlm_q <= dlab ? wbyte : dlm_q;
                  ier_q <= dlab ? ier_q : (wbyte & 8'h0F);
               end
               serial_pkg::REG_FCR: fifo_en_q <= wbyte[0];
               serial_pkg::REG_LCR: lcr_q <= wbyte;
               serial_pkg::REG_MCR: mcr_q <= wbyte & 8'h1F;
               serial_pkg::REG_SCR: scr_q <= wbyte;
               default: ;
            endcase
         end
      end

      // A new divisor is picked up at the next reload, so only the sample period in flight keeps the old length.
      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            div_cnt_q <= 16'h0001;
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            pin_q <= 1'b1;
            tx_line_q <= 1'b1;
            oe_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
         end else if (ce_in) begin
            if (src_tick_q) begin
               div_cnt_q <= (div_cnt_q <= 16'h0001) ? eff_div : div_cnt_q - 16'h0001;
            end
            rx_s1_q <= rxd_w[p];
            rx_s2_q <= rx_s1_q;
            pin_q <= port_can ? can_tx_in : (mcr_q[4] | tx_line_q);
            tx_line_q <= (tx_st_q == serial_pkg::S_START) ? 1'b0 :
                         (tx_st_q == serial_pkg::S_DATA) ? tx_sh_q[0] :
                         (tx_st_q == serial_pkg::S_PARITY) ? tx_par_q : 1'b1;
            oe_q <= (rx_push & ~rxi.ready) | (oe_q & ~lsr_rd);
            pe_q <= (rx_push & rx_perr_q) | (pe_q & ~lsr_rd);
            fe_q <= (rx_push & ~rx_line) | (fe_q & ~lsr_rd);
         end
      end

      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            tx_st_q <= serial_pkg::S_IDLE;
            tx_sub_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
         end else if (ce_in && smp_tick) begin
            tx_sub_q <= (tx_st_q == serial_pkg::S_IDLE) ? 4'h0 : tx_sub_q + 4'h1;
            case (tx_st_q)
               serial_pkg::S_IDLE: begin
                  if (txo.valid) begin
                     tx_sh_q <= txo.data;
                     tx_par_q <= serial_pkg::parity_bit(txo.data, lcr_q[1:0], lcr_q[4]);
                     tx_st_q <= serial_pkg::S_START;
                  end
               end
               serial_pkg::S_START: begin
                  tx_bit_q <= 3'h0;
                  tx_st_q <= (tx_sub_q == serial_pkg::SAMPLE_LAST) ? serial_pkg::S_DATA : tx_st_q;
               end
               serial_pkg::S_DATA: begin
                  if (tx_sub_q == serial_pkg::SAMPLE_LAST) begin
                     tx_sh_q <= tx_sh_q >> 1;
                     tx_bit_q <= (tx_bit_q == last_bit) ? 3'h0 : tx_bit_q + 3'h1;
                     if (tx_bit_q == last_bit) begin
                        tx_st_q <= lcr_q[3] ? serial_pkg::S_PARITY : serial_pkg::S_STOP;
                     end
                  end
               end
               serial_pkg::S_PARITY: begin
                  tx_st_q <= (tx_sub_q == serial_pkg::SAMPLE_LAST) ? serial_pkg::S_STOP : tx_st_q;
               end
               serial_pkg::S_STOP: begin
                  if (tx_sub_q == serial_pkg::SAMPLE_LAST) begin
                     tx_bit_q <= 3'h1;
                     if (!lcr_q[2] || tx_bit_q != 3'h0) begin
                        tx_st_q <= serial_pkg::S_IDLE;
                     end
                  end
               end
               default: tx_st_q <= serial_pkg::S_IDLE;
            endcase
         end
      end

      // Resyncing on every start edge and leaving at mid stop bit gives the rate margin.
      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            rx_st_q <= serial_pkg::S_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_perr_q <= 1'b0;
         end else if (ce_in && smp_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            case (rx_st_q)
               serial_pkg::S_IDLE: begin
                  rx_sub_q <= 4'h0;
                  rx_st_q <= rx_line ? rx_st_q : serial_pkg::S_START;
               end
               serial_pkg::S_START: begin
                  if (rx_sub_q == serial_pkg::SAMPLE_MID) begin
                     rx_sub_q <= 4'h0;
                     rx_bit_q <= 3'h0;
                     rx_sh_q <= 8'h00;
                     rx_perr_q <= 1'b0;
                     rx_st_q <= rx_line ? serial_pkg::S_IDLE : serial_pkg::S_DATA;
                  end
               end
               serial_pkg::S_DATA: begin
                  if (rx_sub_q == serial_pkg::SAMPLE_LAST) begin
                     rx_sh_q[rx_bit_q] <= rx_line;
                     rx_bit_q <= rx_bit_q + 3'h1;
                     if (rx_bit_q == last_bit) begin
                        rx_st_q <= lcr_q[3] ? serial_pkg::S_PARITY : serial_pkg::S_STOP;
                     end
                  end
               end
               serial_pkg::S_PARITY: begin
                  if (rx_sub_q == serial_pkg::SAMPLE_LAST) begin
                     rx_perr_q <= rx_line != serial_pkg::parity_bit(rx_sh_q, lcr_q[1:0], lcr_q[4]);
                     rx_st_q <= serial_pkg::S_STOP;
                  end
               end
               serial_pkg::S_STOP: begin
                  rx_st_q <= (rx_sub_q == serial_pkg::SAMPLE_LAST) ? serial_pkg::S_IDLE : rx_st_q;
               end
               default: rx_st_q <= serial_pkg::S_IDLE;
            endcase
         end
      end
   end
endmodule : serial_port_baud_generator

/* tb/serial_port_baud_generator_properties.sv */
`timescale 1ns/100ps
module serial_checker (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic [31:0] rdata_out,
   input wire logic [1:0] rresp_out,
   input wire logic rvalid_out,
   input wire logic rready_in,
   input wire logic [1:0] bresp_out,
   input wire logic bvalid_out,
   input wire logic bready_in,
   input wire logic txd_a_out,
   input wire logic txd_b_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic rd_go = arvalid_in && arready_out;
   property p_rl; rd_go |=> rvalid_out; endproperty
   a_rl: assert property (p_rl) else $error("read answer late");
   property p_rh; rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out); endproperty
   a_rh: assert property (p_rh) else $error("read data dropped");
   property p_bh; bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out); endproperty
   a_bh: assert property (p_bh) else $error("write answer dropped");
   property p_ar; rvalid_out |-> !arready_out; endproperty
   a_ar: assert property (p_ar) else $error("second read taken");
   property p_se; rd_go && araddr_in > 8'h47 |=> rresp_out == serial_pkg::RESP_SLVERR && rdata_out == 32'h0; endproperty
   a_se: assert property (p_se) else $error("unmapped read accepted");
   property p_ok; rd_go && araddr_in == serial_pkg::CFG_ADDR |=> rresp_out == serial_pkg::RESP_OKAY; endproperty
   a_ok: assert property (p_ok) else $error("config read refused");
   property p_bit; $fell(txd_a_out) |=> !txd_a_out [*8]; endproperty
   a_bit: assert property (p_bit) else $error("line bit too short");
   property p_id; $rose(rst_b_in) |-> txd_a_out && txd_b_out; endproperty
   a_id: assert property (p_id) else $error("lines not idle after reset");
   c_err: cover property (rd_go && araddr_in > 8'h47);
   c_tx: cover property ($fell(txd_a_out));
   c_wr: cover property (bvalid_out && bready_in);
endmodule : serial_checker

/* tb/line_xcvr_model.sv */
`timescale 1ns/100ps
module line_xcvr_model (
   input wire logic clk_in,
   input wire logic txd_in,
   output logic rxd_out
);
   // The line is pulled up, so it idles high between frames.
   initial rxd_out = 1'b1;
   task automatic send(input logic [7:0] b, input int p);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10 * p; i++) begin
         @(posedge clk_in);
         rxd_out <= f[i / p];
      end
      @(posedge clk_in);
   endtask : send
   // The first data bit must be 1, or the start length reads long.
   task automatic recv(output logic [7:0] b, output int len, input real p);
      int t;
      t = 0;
      while (txd_in && t < 9000) begin
         @(posedge clk_in);
         t++;
      end
      len = 0;
      while (!txd_in && len < 9000) begin
         @(posedge clk_in);
         len++;
      end
      t = len;
      for (int i = 0; i < 8; i++) begin
         while (t < $rtoi(p * (i + 1.5))) begin
            @(posedge clk_in);
            t++;
         end
         b[i] = txd_in;
      end
   endtask : recv
endmodule : line_xcvr_model

/* tb/tb_serial_port_baud_generator.sv */
`timescale 1ns/100ps
module tb_serial_port_baud_generator;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ce_in = 1'b1;
   logic [7:0] awaddr_in = 8'h00;
   logic awvalid_in = 1'b0;
   logic [31:0] wdata_in = 32'h00000000;
   logic [3:0] wstrb_in = 4'hF;
   logic wvalid_in = 1'b0;
   logic bready_in = 1'b0;
   logic [7:0] araddr_in = 8'h00;
   logic arvalid_in = 1'b0;
   logic rready_in = 1'b0;
   logic rxd_a_in;
   logic rxd_b_in = 1'b1;
   logic can_tx_in = 1'b1;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, txd_a_out, txd_b_out, can_rx_out;
   logic [1:0] bresp_out, rresp_out;
   logic [31:0] rdata_out;
   int num_errors = 0;
   int checks = 0;
   always #2.5 clk_in = ~clk_in;
   serial_port_baud_generator serial_port_baud_generator_inst (.*);
   line_xcvr_model line_xcvr_model_inst (.clk_in(clk_in), .txd_in(txd_a_out), .rxd_out(rxd_a_in));
   task automatic results;
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic guard(input int n);
      if (n >= 9000) begin
         num_errors++;
         results();
      end
   endtask : guard
   // Ready is raised only once valid shows, so the slave's hold behaviour is exercised.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output int n);
      @(posedge clk_in);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         if (awready_out) awvalid_in <= 1'b0;
         if (wready_out) wvalid_in <= 1'b0;
         if (bvalid_out && !bready_in) bready_in <= 1'b1;
      end while (!(bvalid_out && bready_in) && n < 9000);
      r = bresp_out;
      bready_in <= 1'b0;
      guard(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         if (arready_out) arvalid_in <= 1'b0;
         if (rvalid_out && !rready_in) rready_in <= 1'b1;
      end while (!(rvalid_out && rready_in) && n < 9000);
      d = rdata_out;
      r = rresp_out;
      rready_in <= 1'b0;
      guard(n);
   endtask : rd
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      int n;
      wr(a, d, r, n);
      chk({30'h0, r}, 32'h00000000);
   endtask : w
   task automatic setdiv(input logic [7:0] p, input logic [15:0] d);
      w(p + 8'h0C, 32'h00000080);
      w(p, {24'h0, d[7:0]});
      w(p + 8'h04, {24'h0, d[15:8]});
      w(p + 8'h0C, 32'h00000003);
   endtask : setdiv
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rd(serial_pkg::CFG_ADDR, d, r);
      chk(d, 32'h00000105);
      rd(serial_pkg::SRC_ADDR, d, r);
      chk(d, 32'h000061A8);
      rd(8'h0C, d, r);
      chk(d, 32'h00000003);
      rd(8'h48, d, r);
      chk({30'h0, r}, 32'h00000002);
      $display("reset test done");
   endtask : t_reset
   task automatic t_src;
      logic [31:0] d;
      logic [1:0] r;
      w(serial_pkg::CFG_ADDR, 32'h00001F1F);
      rd(serial_pkg::SRC_ADDR, d, r);
      chk(d, 32'h0002EE00);
      w(serial_pkg::CFG_ADDR, 32'h00000305);
      rd(serial_pkg::SRC_ADDR, d, r);
      chk(d, 32'h000124F8);
      w(serial_pkg::CFG_ADDR, 32'h00000112);
      $display("source test done");
   endtask : t_src
   task automatic t_fifo;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      w(8'h28, 32'h00000001);
      for (int i = 0; i < 67; i++) begin
         wr(8'h20, i, r, n);
         if (i > 64) chk(n > 100, i == 66);
      end
      w(8'h28, 32'h00000007);
      rd(8'h34, d, r);
      chk(d[5], 1'b1);
      $display("fifo test done");
   endtask : t_fifo
   task automatic t_can;
      rxd_b_in <= 1'b0;
      can_tx_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(can_rx_out, 1'b1);
      w(serial_pkg::CFG_ADDR, 32'h00010112);
      repeat (6) @(posedge clk_in);
      chk(txd_b_out, 1'b0);
      chk(can_rx_out, 1'b0);
      rxd_b_in <= 1'b1;
      can_tx_in <= 1'b1;
      $display("route test done");
   endtask : t_can
   task automatic t_tx;
      logic [7:0] b;
      int len;
      for (int d = 1; d <= 3; d += 2) begin
         setdiv(8'h00, d[15:0]);
         fork
            line_xcvr_model_inst.recv(b, len, 200.0 * 16 * d / 192);
            w(8'h00, 32'h000000A5);
         join
         chk(b, 8'hA5);
         chk(len >= 16 * d && len <= 17 * d + 1, 1'b1);
         repeat (40 * d) @(posedge clk_in);
      end
      $display("transmit test done");
   endtask : t_tx
   task automatic t_rx;
      logic [31:0] d;
      logic [1:0] r;
      setdiv(8'h00, 16'h0004);
      for (int k = 0; k < 2; k++) begin
         line_xcvr_model_inst.send(8'h3C + k * 8'h87, 68 - k * 3);
         rd(8'h14, d, r);
         chk(d[0], 1'b1);
         rd(8'h00, d, r);
         chk(d, 32'h0000003C + k * 32'h87);
      end
      $display("receive test done");
   endtask : t_rx
   initial begin
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_reset();
      t_src();
      t_fifo();
      t_can();
      t_tx();
      t_rx();
      results();
   end
endmodule : tb_serial_port_baud_generator
bind serial_port_baud_generator serial_checker serial_checker_inst (.*);
